/* rtl/imad_pkg.sv */
// Constants, types and helpers for the internal memory address decoder
package imad_pkg;

    // ==========================================================
    // Widths and counts
    localparam int IMAD_NBLK = 4;
    localparam int IMAD_NROM = 2;
    localparam int IMAD_OFS_W = 17;

    typedef logic [31:0] imad_addr_t;

    // ==========================================================
    // Region kinds and address views
    typedef enum logic [2:0]
    {
        IMAD_RG_IDLE = 3'h0,
        IMAD_RG_PERIPH = 3'h1,
        IMAD_RG_ROM = 3'h3,
        IMAD_RG_RSVD = 3'h2,
        IMAD_RG_SRAM = 3'h6
    } imad_region_t;

    typedef enum logic [1:0]
    {
        IMAD_V_LONG = 2'h0,
        IMAD_V_EXT48 = 2'h1,
        IMAD_V_NORM32 = 2'h2,
        IMAD_V_SHORT16 = 2'h3
    } imad_view_t;

    // Word width in bits per view, indexed by imad_view_t
    localparam logic [6:0] IMAD_VIEW_BITS [4] =
        '{7'h40, 7'h30, 7'h20, 7'h10};

    // ==========================================================
    // Address space boundaries
    localparam imad_addr_t IMAD_PERIPH_HI = 32'h0003ffff;
    localparam imad_addr_t IMAD_LONG_LO = 32'h00040000;
    localparam imad_addr_t IMAD_WIDE_LO = 32'h00080000;
    localparam imad_addr_t IMAD_SHORT_LO = 32'h00100000;
    localparam imad_addr_t IMAD_SPACE_HI = 32'h001fffff;

    // SRAM block bounds, [view][block]
    localparam imad_addr_t IMAD_SRAM_LO [4][4] = '{
        '{32'h00049000, 32'h00059000, 32'h00060000, 32'h00070000},
        '{32'h0008c000, 32'h000ac000, 32'h000c0000, 32'h000e0000},
        '{32'h00092000, 32'h000b2000, 32'h000c0000, 32'h000e0000},
        '{32'h00124000, 32'h00164000, 32'h00180000, 32'h001c0000}};
    localparam imad_addr_t IMAD_SRAM_HI [4][4] = '{
        '{32'h0004cfff, 32'h0005cfff, 32'h00061fff, 32'h00071fff},
        '{32'h00091554, 32'h000b1554, 32'h000c2aa9, 32'h000e2aa9},
        '{32'h00099fff, 32'h000b9fff, 32'h000c3fff, 32'h000e3fff},
        '{32'h00133fff, 32'h00173fff, 32'h00187fff, 32'h001c7fff}};

    // Reserved ROM bounds of blocks 0 and 1, [view][block]
    localparam imad_addr_t IMAD_ROM_LO [4][2] = '{
        '{32'h00040000, 32'h00050000},
        '{32'h00080000, 32'h000a0000},
        '{32'h00080000, 32'h000a0000},
        '{32'h00100000, 32'h00140000}};
    localparam imad_addr_t IMAD_ROM_HI [4][2] = '{
        '{32'h00047fff, 32'h00057fff},
        '{32'h0008aaa9, 32'h000aaaa9},
        '{32'h0008ffff, 32'h000affff},
        '{32'h0011ffff, 32'h0015ffff}};

    // ==========================================================
    // Registered answer of one requester, and the decoder state
    typedef struct packed
    {
        logic valid;
        imad_region_t region;
        imad_view_t view;
        logic [6:0] bits;
        logic [3:0] blk_sel;
        logic [IMAD_OFS_W-1:0] offset;
        logic nomem;
    } imad_resp_t;

    typedef struct packed
    {
        imad_resp_t core;
        imad_resp_t io;
        logic [3:0] shared;
    } imad_state_t;

    localparam imad_resp_t IMAD_RESP_RST = '0;
    localparam imad_state_t IMAD_STATE_RST = '0;

    // ==========================================================
    // Helpers
    function automatic logic imad_in_rng(imad_addr_t a, imad_addr_t lo,
        imad_addr_t hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // The 48-bit and 32-bit views share addresses; the ext flag picks
    function automatic imad_view_t imad_view_of(imad_addr_t a, logic ext);
        if (a < IMAD_WIDE_LO)
            return IMAD_V_LONG;
        else if (a < IMAD_SHORT_LO)
            return ext ? IMAD_V_EXT48 : IMAD_V_NORM32;
        else
            return IMAD_V_SHORT16;
    endfunction

endpackage

/* rtl/imad_dec_if.sv */
// Carrier between the address classifier and the offset calculator
`timescale 1ns/1ns
interface imad_dec_if;
    import imad_pkg::*;

    imad_addr_t addr;
    logic ext;
    imad_region_t region;
    imad_view_t view;
    logic [1:0] blk;
    logic [IMAD_OFS_W-1:0] offset;

    modport cls (input addr, input ext, output region, output view,
        output blk);
    modport ofs (input addr, input region, input view, input blk,
        output offset);
    modport top (output addr, output ext, input region, input view,
        input blk, input offset);
endinterface

/* rtl/imad_classify.sv */
// Classifies one address into region kind, view and block
`timescale 1ns/1ns
module imad_classify
(
    imad_dec_if.cls dec // Address in, class out
);
    import imad_pkg::*;

    // ==========================================================
    // Region search; anything unmatched in the map is a hole
    always_comb
    begin
        int vi;
        vi = 0;
        dec.view = IMAD_V_NORM32;
        dec.region = IMAD_RG_RSVD; // R3 R5 R7 R9 R11 R13
        dec.blk = 2'h0;
        if (dec.addr <= IMAD_PERIPH_HI)
        begin
            dec.region = IMAD_RG_PERIPH; // R1
        end
        else if (dec.addr > IMAD_SPACE_HI)
        begin
            dec.view = IMAD_V_SHORT16;
        end
        else
        begin
            dec.view = imad_view_of(dec.addr, dec.ext); // R15 R16
            vi = int'(dec.view);
            for (int b = 0; b < IMAD_NBLK; b++)
            begin
                if (imad_in_rng(dec.addr, IMAD_SRAM_LO[vi][b],
                    IMAD_SRAM_HI[vi][b]))
                begin
                    dec.region = IMAD_RG_SRAM; // R4 R8 R10 R12 R17
                    dec.blk = 2'(b);
                end
            end
            for (int b = 0; b < IMAD_NROM; b++)
            begin
                if (imad_in_rng(dec.addr, IMAD_ROM_LO[vi][b],
                    IMAD_ROM_HI[vi][b]))
                begin
                    dec.region = IMAD_RG_ROM; // R2 R6
                end
            end
        end
    end
endmodule

/* rtl/imad_offset.sv */
// Word offset of an address within its SRAM block
`timescale 1ns/1ns
module imad_offset
(
    imad_dec_if.ofs dec // Class in, offset out
);
    import imad_pkg::*;

    // ==========================================================
    // Offset counts words of the view in use, zero off SRAM
    always_comb
    begin
        imad_addr_t diff;
        diff = dec.addr - IMAD_SRAM_LO[int'(dec.view)][dec.blk];
        dec.offset = '0;
        if (dec.region == IMAD_RG_SRAM)
            dec.offset = diff[IMAD_OFS_W-1:0]; // R16 R18
    end
endmodule

/* rtl/imad_top.sv */
// Internal memory address decoder for core and I/O processor requests
`timescale 1ns/1ns

// Contract
// R1 - Addresses 0x0 to 0x3FFFF go to the register space, never memory.
// R2 - Block 0 ROM ranges in all four views decode as reserved.
// R3 - The gap between block 0 ROM and SRAM decodes as reserved.
// R4 - Block 0 SRAM ranges in all four views select block 0.
// R5 - Space above block 0 SRAM up to block 1 ROM is reserved.
// R6 - Block 1 ROM ranges in all four views decode as reserved.
// R7 - The gap between block 1 ROM and SRAM decodes as reserved.
// R8 - Block 1 SRAM ranges in all four views select block 1.
// R9 - Space above block 1 SRAM up to block 2 is reserved.
// R10 - Block 2 SRAM ranges in all four views select block 2.
// R11 - Space above block 2 SRAM up to block 3 is reserved.
// R12 - Block 3 SRAM ranges in all four views select block 3.
// R13 - Space above block 3 SRAM to the view's end is reserved.
// R14 - Core and I/O requests decode together, each in one cycle.
// R15 - Four views: 64, 48, 32 and 16 bit words over one storage.
// R16 - Access width follows the view the address falls in.
// R17 - Every SRAM word is reachable through each of the four views.
// R18 - Answer gives block, view and offset, or a no-memory flag.
module imad_top
(
    input wire logic i_clk, // Core clock
    input wire logic i_srst, // Sync reset, high
    input wire logic i_core_valid, // Core request
    input wire imad_pkg::imad_addr_t i_core_addr, // Core address
    input wire logic i_core_ext48, // Core wants 48-bit view
    input wire logic i_io_valid, // I/O request
    input wire imad_pkg::imad_addr_t i_io_addr, // I/O address
    input wire logic i_io_ext48, // I/O wants 48-bit view
    output logic o_core_valid, // Core answer valid
    output imad_pkg::imad_region_t o_core_region, // Core region
    output imad_pkg::imad_view_t o_core_view, // Core view
    output logic [6:0] o_core_bits, // Core word width
    output logic [3:0] o_core_blk_sel, // Core block, one-hot
    output logic [16:0] o_core_offset, // Core word offset
    output logic o_core_nomem, // Core no memory
    output logic o_io_valid, // I/O answer valid
    output imad_pkg::imad_region_t o_io_region, // I/O region
    output imad_pkg::imad_view_t o_io_view, // I/O view
    output logic [6:0] o_io_bits, // I/O word width
    output logic [3:0] o_io_blk_sel, // I/O block, one-hot
    output logic [16:0] o_io_offset, // I/O word offset
    output logic o_io_nomem, // I/O no memory
    output logic [3:0] o_shared_blk // Blocks hit by both
);
    import imad_pkg::*;

    // ==========================================================
    // Two decode lanes, one per requester
    imad_dec_if core_dec ();
    imad_dec_if io_dec ();

    imad_state_t st_r;
    imad_state_t st_nxt;

    // Each lane has its own classifier so neither waits
    assign core_dec.addr = i_core_addr; // R14
    assign core_dec.ext = i_core_ext48;
    assign io_dec.addr = i_io_addr; // R14
    assign io_dec.ext = i_io_ext48;

    imad_classify u_core_cls
    (
        .dec(core_dec)
    );

    imad_offset u_core_ofs
    (
        .dec(core_dec)
    );

    imad_classify u_io_cls
    (
        .dec(io_dec)
    );

    imad_offset u_io_ofs
    (
        .dec(io_dec)
    );

    // ==========================================================
    // Answer builder, shared by both lanes
    function automatic imad_resp_t mk_resp(logic v, imad_region_t rg,
        imad_view_t vw, logic [1:0] blk, logic [IMAD_OFS_W-1:0] ofs);
        imad_resp_t r;
        r = IMAD_RESP_RST;
        if (v)
        begin
            r.valid = 1'b1;
            r.region = rg;
            r.view = vw;
            r.bits = IMAD_VIEW_BITS[int'(vw)]; // R15 R16
            r.nomem = (rg != IMAD_RG_SRAM); // R18
            if (rg == IMAD_RG_SRAM)
            begin
                r.blk_sel = 4'h1 << blk; // R18
                r.offset = ofs;
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Next state: both lanes answer in the cycle after the request
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.core = mk_resp(i_core_valid, core_dec.region,
            core_dec.view, core_dec.blk, core_dec.offset); // R14
        st_nxt.io = mk_resp(i_io_valid, io_dec.region,
            io_dec.view, io_dec.blk, io_dec.offset); // R14
        // Dual-ported blocks: a shared hit is a note, not a stall
        st_nxt.shared = st_nxt.core.blk_sel & st_nxt.io.blk_sel; // R14
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st_r <= IMAD_STATE_RST;
        else
            st_r <= st_nxt;
    end

    // ==========================================================
    // Outputs straight from the state register
    assign o_core_valid = st_r.core.valid;
    assign o_core_region = st_r.core.region;
    assign o_core_view = st_r.core.view;
    assign o_core_bits = st_r.core.bits;
    assign o_core_blk_sel = st_r.core.blk_sel;
    assign o_core_offset = st_r.core.offset;
    assign o_core_nomem = st_r.core.nomem;
    assign o_io_valid = st_r.io.valid;
    assign o_io_region = st_r.io.region;
    assign o_io_view = st_r.io.view;
    assign o_io_bits = st_r.io.bits;
    assign o_io_blk_sel = st_r.io.blk_sel;
    assign o_io_offset = st_r.io.offset;
    assign o_io_nomem = st_r.io.nomem;
    assign o_shared_blk = st_r.shared;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence core_req_in(imad_addr_t lo, imad_addr_t hi);
        i_core_valid && imad_in_rng(i_core_addr, lo, hi);
    endsequence

    sequence io_req_in(imad_addr_t lo, imad_addr_t hi);
        i_io_valid && imad_in_rng(i_io_addr, lo, hi);
    endsequence

    sequence core_rsvd;
        o_core_valid && o_core_region == IMAD_RG_RSVD && o_core_nomem;
    endsequence

    sequence io_rsvd;
        o_io_valid && o_io_region == IMAD_RG_RSVD && o_io_nomem;
    endsequence

    chk_periph_route: assert property ( // R1
        core_req_in(32'h0, IMAD_PERIPH_HI) |=>
        o_core_region == IMAD_RG_PERIPH && o_core_nomem &&
        o_core_blk_sel == 4'h0)
        else $error("register space address reached memory");

    chk_rom0_rsvd: assert property ( // R2
        core_req_in(IMAD_ROM_LO[0][0], IMAD_ROM_HI[0][0]) |=>
        o_core_region == IMAD_RG_ROM && o_core_nomem)
        else $error("block 0 ROM not reserved");

    chk_hole0_rsvd: assert property ( // R3
        io_req_in(IMAD_ROM_HI[3][0] + 32'h1,
            IMAD_SRAM_LO[3][0] - 32'h1) |=> io_rsvd)
        else $error("hole below block 0 SRAM not reserved");

    chk_sram0_ext: assert property ( // R4
        core_req_in(IMAD_SRAM_LO[1][0], IMAD_SRAM_HI[1][0]) ##0
        i_core_ext48 |=> o_core_blk_sel == 4'h1 &&
        o_core_bits == 7'h30 &&
        o_core_offset == 17'($past(i_core_addr) - IMAD_SRAM_LO[1][0]))
        else $error("48-bit block 0 SRAM decode wrong");

    chk_above0_rsvd: assert property ( // R5
        core_req_in(IMAD_SRAM_HI[2][0] + 32'h1,
            IMAD_ROM_LO[2][1] - 32'h1) ##0 !i_core_ext48 |=> core_rsvd)
        else $error("space above block 0 SRAM not reserved");

    chk_rom1_rsvd: assert property ( // R6
        io_req_in(IMAD_ROM_LO[3][1], IMAD_ROM_HI[3][1]) |=>
        o_io_region == IMAD_RG_ROM && o_io_blk_sel == 4'h0)
        else $error("block 1 ROM not reserved");

    chk_hole1_rsvd: assert property ( // R7
        core_req_in(IMAD_ROM_HI[0][1] + 32'h1,
            IMAD_SRAM_LO[0][1] - 32'h1) |=> core_rsvd)
        else $error("hole below block 1 SRAM not reserved");

    chk_sram1_norm: assert property ( // R8
        io_req_in(IMAD_SRAM_LO[2][1], IMAD_SRAM_HI[2][1]) ##0
        !i_io_ext48 |=> o_io_blk_sel == 4'h2 && o_io_bits == 7'h20 &&
        o_io_offset == 17'($past(i_io_addr) - IMAD_SRAM_LO[2][1]))
        else $error("32-bit block 1 SRAM decode wrong");

    chk_above1_rsvd: assert property ( // R9
        io_req_in(IMAD_SRAM_HI[3][1] + 32'h1,
            IMAD_SRAM_LO[3][2] - 32'h1) |=> io_rsvd)
        else $error("space above block 1 SRAM not reserved");

    chk_sram2_long: assert property ( // R10
        core_req_in(IMAD_SRAM_LO[0][2], IMAD_SRAM_HI[0][2]) |=>
        o_core_blk_sel == 4'h4 && o_core_view == IMAD_V_LONG &&
        o_core_offset == 17'($past(i_core_addr) - IMAD_SRAM_LO[0][2]))
        else $error("64-bit block 2 SRAM decode wrong");

    chk_above2_rsvd: assert property ( // R11
        core_req_in(IMAD_SRAM_HI[1][2] + 32'h1,
            IMAD_SRAM_LO[1][3] - 32'h1) ##0 i_core_ext48 |=> core_rsvd)
        else $error("space above block 2 SRAM not reserved");

    chk_sram3_short: assert property ( // R12
        io_req_in(IMAD_SRAM_LO[3][3], IMAD_SRAM_HI[3][3]) |=>
        o_io_blk_sel == 4'h8 && o_io_bits == 7'h10 && !o_io_nomem)
        else $error("16-bit block 3 SRAM decode wrong");

    chk_above3_rsvd: assert property ( // R13
        io_req_in(IMAD_SRAM_HI[3][3] + 32'h1, IMAD_SPACE_HI) |=> io_rsvd)
        else $error("space above block 3 SRAM not reserved");

    chk_dual_lane: assert property ( // R14
        i_core_valid && i_io_valid |=> o_core_valid && o_io_valid &&
        o_shared_blk == (o_core_blk_sel & o_io_blk_sel))
        else $error("simultaneous requests not both answered");

    chk_view_width: assert property ( // R15 R16
        o_core_valid |-> o_core_bits == IMAD_VIEW_BITS[int'(o_core_view)])
        else $error("word width does not match view");

    chk_sram_onehot: assert property ( // R17 R18
        o_io_valid |-> (o_io_region == IMAD_RG_SRAM) ?
        ($onehot(o_io_blk_sel) && !o_io_nomem) :
        (o_io_blk_sel == 4'h0 && o_io_nomem))
        else $error("block select and no-memory flag disagree");

    chk_idle_quiet: assert property ( // R18
        !i_core_valid |=> !o_core_valid && o_core_blk_sel == 4'h0 &&
        !o_core_nomem)
        else $error("answer without request");

endmodule

/* dv/imad_host_model.sv */
// Request side model of the core and I/O processor address buses
`timescale 1ns/1ns
module imad_host_model
(
    input wire logic i_clk, // Core clock
    output logic o_core_valid, // Core request
    output imad_pkg::imad_addr_t o_core_addr, // Core address
    output logic o_core_ext48, // Core 48-bit view
    output logic o_io_valid, // I/O request
    output imad_pkg::imad_addr_t o_io_addr, // I/O address
    output logic o_io_ext48 // I/O 48-bit view
);
    import imad_pkg::*;

    // ==========================================================
    // Request staged by the bench for the next falling edge
    logic pend;
    logic pcv;
    logic pce;
    logic piv;
    logic pie;
    imad_addr_t pca;
    imad_addr_t pia;

    // Quiet buses at time zero
    initial
    begin
        pend = 1'b0;
        o_core_valid = 1'b0;
        o_core_addr = '0;
        o_core_ext48 = 1'b0;
        o_io_valid = 1'b0;
        o_io_addr = '0;
        o_io_ext48 = 1'b0;
    end

    task automatic post(input logic cv, input imad_addr_t ca,
        input logic ce, input logic iv, input imad_addr_t ia,
        input logic ie);
        pcv = cv;
        pca = ca;
        pce = ce;
        piv = iv;
        pia = ia;
        pie = ie;
        pend = 1'b1;
    endtask

    // Released lanes drop valid and flip address and ext, so a stale address returns only on every second idle cycle
    always @(negedge i_clk)
    begin
        o_core_valid <= pend & pcv;
        o_core_addr <= (pend & pcv) ? pca : ~o_core_addr;
        o_core_ext48 <= (pend & pcv) ? pce : ~o_core_ext48;
        o_io_valid <= pend & piv;
        o_io_addr <= (pend & piv) ? pia : ~o_io_addr;
        o_io_ext48 <= (pend & piv) ? pie : ~o_io_ext48;
        pend <= 1'b0;
    end
endmodule

/* dv/tb_internal_memory_address_decoder.sv */
// Self-checking bench for the internal memory address decoder
`timescale 1ns/1ns
module tb_internal_memory_address_decoder;
    import imad_pkg::*;

    // ==========================================================
    // Address, ext, region, view, one-hot block, word offset
    typedef struct packed
    {
        imad_addr_t a;
        logic e;
        logic [2:0] rg;
        logic [1:0] vw;
        logic [3:0] sel;
        logic [16:0] ofs;
    } imad_vec_t;
    localparam int NV = 36;
    localparam imad_vec_t TBL [NV] = '{
        '{32'h00000000, 1'b0, 3'h1, 2'h2, 4'h0, 17'h0},
        '{32'h0003ffff, 1'b1, 3'h1, 2'h2, 4'h0, 17'h0},
        '{32'h00040000, 1'b0, 3'h3, 2'h0, 4'h0, 17'h0},
        '{32'h0008aaa9, 1'b1, 3'h3, 2'h1, 4'h0, 17'h0},
        '{32'h0011ffff, 1'b0, 3'h3, 2'h3, 4'h0, 17'h0},
        '{32'h00048000, 1'b0, 3'h2, 2'h0, 4'h0, 17'h0},
        '{32'h0008aaaa, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h0008aaaa, 1'b0, 3'h3, 2'h2, 4'h0, 17'h0},
        '{32'h00049000, 1'b0, 3'h6, 2'h0, 4'h1, 17'h0},
        '{32'h00091554, 1'b1, 3'h6, 2'h1, 4'h1, 17'h5554},
        '{32'h00099fff, 1'b0, 3'h6, 2'h2, 4'h1, 17'h7fff},
        '{32'h00133fff, 1'b0, 3'h6, 2'h3, 4'h1, 17'hffff},
        '{32'h00091555, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h00095555, 1'b0, 3'h6, 2'h2, 4'h1, 17'h3555},
        '{32'h00050000, 1'b1, 3'h3, 2'h0, 4'h0, 17'h0},
        '{32'h000aaaaa, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h0005cfff, 1'b0, 3'h6, 2'h0, 4'h2, 17'h3fff},
        '{32'h00164000, 1'b0, 3'h6, 2'h3, 4'h2, 17'h0},
        '{32'h000b1555, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h000c2aa9, 1'b1, 3'h6, 2'h1, 4'h4, 17'h2aa9},
        '{32'h00187fff, 1'b0, 3'h6, 2'h3, 4'h4, 17'h7fff},
        '{32'h00062000, 1'b0, 3'h2, 2'h0, 4'h0, 17'h0},
        '{32'h00188000, 1'b0, 3'h2, 2'h3, 4'h0, 17'h0},
        '{32'h00070000, 1'b0, 3'h6, 2'h0, 4'h8, 17'h0},
        '{32'h000e3fff, 1'b0, 3'h6, 2'h2, 4'h8, 17'h3fff},
        '{32'h000e2aaa, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h001fffff, 1'b0, 3'h2, 2'h3, 4'h0, 17'h0},
        '{32'h00058000, 1'b0, 3'h2, 2'h0, 4'h0, 17'h0},
        '{32'h0009a000, 1'b0, 3'h2, 2'h2, 4'h0, 17'h0},
        '{32'h000c2aaa, 1'b1, 3'h2, 2'h1, 4'h0, 17'h0},
        '{32'h00061fff, 1'b0, 3'h6, 2'h0, 4'h4, 17'h1fff},
        '{32'h00123fff, 1'b0, 3'h2, 2'h3, 4'h0, 17'h0},
        '{32'h00140000, 1'b0, 3'h3, 2'h3, 4'h0, 17'h0},
        '{32'h00174000, 1'b0, 3'h2, 2'h3, 4'h0, 17'h0},
        '{32'h001c7fff, 1'b0, 3'h6, 2'h3, 4'h8, 17'h7fff},
        '{32'h00200000, 1'b0, 3'h2, 2'h3, 4'h0, 17'h0}};

    // ==========================================================
    // Signals
    logic clk;
    logic srst;
    logic core_req;
    logic core_ext;
    logic io_req;
    logic io_ext;
    imad_addr_t core_addr;
    imad_addr_t io_addr;
    logic core_vld;
    logic io_vld;
    imad_region_t core_rg;
    imad_region_t io_rg;
    imad_view_t core_vw;
    imad_view_t io_vw;
    logic [6:0] core_bits;
    logic [6:0] io_bits;
    logic [3:0] core_sel;
    logic [3:0] io_sel;
    logic [16:0] core_ofs;
    logic [16:0] io_ofs;
    logic core_nomem;
    logic io_nomem;
    logic [3:0] shared;
    int err_total;
    int n_checks;
    int cyc;

    imad_host_model imad_host_model_inst
    (
        .i_clk(clk),
        .o_core_valid(core_req),
        .o_core_addr(core_addr),
        .o_core_ext48(core_ext),
        .o_io_valid(io_req),
        .o_io_addr(io_addr),
        .o_io_ext48(io_ext)
    );

    imad_top imad_top_inst
    (
        .i_clk(clk),
        .i_srst(srst),
        .i_core_valid(core_req),
        .i_core_addr(core_addr),
        .i_core_ext48(core_ext),
        .i_io_valid(io_req),
        .i_io_addr(io_addr),
        .i_io_ext48(io_ext),
        .o_core_valid(core_vld),
        .o_core_region(core_rg),
        .o_core_view(core_vw),
        .o_core_bits(core_bits),
        .o_core_blk_sel(core_sel),
        .o_core_offset(core_ofs),
        .o_core_nomem(core_nomem),
        .o_io_valid(io_vld),
        .o_io_region(io_rg),
        .o_io_view(io_vw),
        .o_io_bits(io_bits),
        .o_io_blk_sel(io_sel),
        .o_io_offset(io_ofs),
        .o_io_nomem(io_nomem),
        .o_shared_blk(shared)
    );

    // ==========================================================
    // Clock and hang guard, sized well past the table run
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            final_report();
        end
    end

    // ==========================================================
    // Checking helpers
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk_lane(input string ln, input logic vld,
        input logic [2:0] rg, input logic [1:0] vw, input logic [6:0] bt,
        input logic [3:0] sel, input logic [16:0] ofs, input logic nm,
        input imad_vec_t e);
        logic [6:0] eb;
        eb = (e.vw == 2'h0) ? 7'h40 : (e.vw == 2'h1) ? 7'h30 :
            (e.vw == 2'h2) ? 7'h20 : 7'h10;
        check({ln, " valid"}, 32'(vld), 32'h1);
        check({ln, " region"}, 32'(rg), 32'(e.rg));
        check({ln, " view"}, 32'(vw), 32'(e.vw));
        check({ln, " bits"}, 32'(bt), 32'(eb));
        check({ln, " block"}, 32'(sel), 32'(e.sel));
        check({ln, " offset"}, 32'(ofs), 32'(e.ofs));
        check({ln, " nomem"}, 32'(nm), 32'(e.rg != 3'h6));
    endtask

    task automatic chk_idle(input string ln, input logic vld,
        input logic [3:0] sel, input logic nm);
        check({ln, " valid"}, 32'(vld), 32'h0);
        check({ln, " block"}, 32'(sel), 32'h0);
        check({ln, " nomem"}, 32'(nm), 32'h0);
    endtask

    // ==========================================================
    // Scenarios
    // A request offered during reset must leave every answer quiet
    task automatic test_reset();
        repeat (2) @(posedge clk);
        #1;
        imad_host_model_inst.post(1'b1, 32'h00049000, 1'b0, 1'b1,
            32'h00060000, 1'b0);
        @(negedge clk);
        @(negedge clk);
        #1;
        chk_idle("core rst", core_vld, core_sel, core_nomem);
        chk_idle("io rst", io_vld, io_sel, io_nomem);
        // Release after the fifth rising edge, clear of the model's edge
        repeat (2) @(negedge clk);
        #1;
        srst = 1'b0;
        $display("test_reset done");
    endtask

    // Back-to-back table walk, io lane runs the table in reverse
    task automatic test_table();
        imad_vec_t c;
        imad_vec_t p;
        for (int k = 0; k <= NV; k++)
        begin
            if (k < NV)
                imad_host_model_inst.post(1'b1, TBL[k].a, TBL[k].e, 1'b1,
                    TBL[NV-1-k].a, TBL[NV-1-k].e);
            else
                imad_host_model_inst.post(1'b0, '0, 1'b0, 1'b0, '0, 1'b0);
            @(negedge clk);
            #1;
            if (k > 0)
            begin
                c = TBL[k-1];
                p = TBL[NV-k];
                chk_lane("core", core_vld, core_rg, core_vw, core_bits,
                    core_sel, core_ofs, core_nomem, c);
                chk_lane("io", io_vld, io_rg, io_vw, io_bits,
                    io_sel, io_ofs, io_nomem, p);
                check("shared", 32'(shared), 32'(c.sel & p.sel));
            end
        end
        @(negedge clk);
        #1;
        chk_idle("core gap", core_vld, core_sel, core_nomem);
        chk_idle("io gap", io_vld, io_sel, io_nomem);
        $display("test_table done");
    endtask

    // Both lanes on block 1 at once, then the core lane alone
    task automatic test_shared();
        imad_host_model_inst.post(1'b1, 32'h00059000, 1'b0, 1'b1,
            32'h000b2000, 1'b0);
        @(negedge clk);
        #1;
        imad_host_model_inst.post(1'b1, 32'h00164001, 1'b0, 1'b0,
            '0, 1'b0);
        @(negedge clk);
        #1;
        chk_lane("core sh", core_vld, core_rg, core_vw, core_bits,
            core_sel, core_ofs, core_nomem,
            '{32'h00059000, 1'b0, 3'h6, 2'h0, 4'h2, 17'h0});
        chk_lane("io sh", io_vld, io_rg, io_vw, io_bits, io_sel, io_ofs,
            io_nomem, '{32'h000b2000, 1'b0, 3'h6, 2'h2, 4'h2, 17'h0});
        check("shared both", 32'(shared), 32'h2);
        @(negedge clk);
        #1;
        chk_lane("core solo", core_vld, core_rg, core_vw, core_bits,
            core_sel, core_ofs, core_nomem,
            '{32'h00164001, 1'b0, 3'h6, 2'h3, 4'h2, 17'h1});
        chk_idle("io solo", io_vld, io_sel, io_nomem);
        check("shared solo", 32'(shared), 32'h0);
        $display("test_shared done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        srst = 1'b1;
        err_total = 0;
        n_checks = 0;
        cyc = 0;
        test_reset();
        test_table();
        test_shared();
        final_report();
    end
endmodule
